// >>> inc/asm_defines.vh
`ifndef ASM_DEFINES_VH
`define ASM_DEFINES_VH

// =============================
// Register offsets
`define ASM_ADDR_W 8
`define ASM_OFS_CLIP_STATUS 8'h24
`define ASM_OFS_ILIM_STATUS 8'h25
`define ASM_OFS_CTRL4 8'h26
`define ASM_OFS_LINE_MODE 8'h00
`define ASM_OFS_MISC3 8'h21
`define ASM_OFS_CLIP_CTRL 8'h22
`define ASM_OFS_SWFREQ 8'h27

// =============================
// Reset values
`define ASM_RST_CTRL4 8'h40
`define ASM_RST_ZERO 8'h00
`define ASM_RST_CLIP_CTRL 8'h01
`define ASM_RST_HPF 3'h0

// =============================
// Field positions
`define ASM_BIT_FLAG 0
`define ASM_BIT_BIT_CLOCK_PHASE_INVERT 3
`define ASM_HPF_MSB 2
`define ASM_HPF_LSB 0
`define ASM_BIT_CLIP_ROUTE 2
`define ASM_BIT_CLIP_EN 0
`define ASM_BIT_ILIM_MASK 5
`define ASM_BIT_LINE_MODE 0
`define ASM_SWF_MSB 2
`define ASM_SWF_LSB 0

// =============================
// Switching frequency ratio codes
`define ASM_SWF_38 3'h0
`define ASM_SWF_44 3'h1
`define ASM_SWF_48 3'h2
`define ASM_SWF_8 3'h3
`define ASM_SWF_10 3'h4
`define ASM_RATIO_38 6'h26
`define ASM_RATIO_44 6'h2C
`define ASM_RATIO_48 6'h30
`define ASM_RATIO_8 6'h08
`define ASM_RATIO_10 6'h0A

`endif

// >>> rtl/asm_status_misc_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "asm_defines.vh"

// Operation
// - Clip flag at bit0, upper bits zero
// - Current-limit warning flag at bit0, read-only
// - Bit3 selects inverted equal-frequency clock phase
// - Bits 2:0 select high-pass corner, reset 000
// - Control 4 resets to 0x40, all eight bits writable
// - Offer 38, 44, 48 times sample rate
// - Offer 8, 10 times sample rate
// - Line-driver mode selected via register 0x00
// - Clip routed to warning or fault pin
// - Current-limit on warning pin unless masked
module asm_status_misc_regs
(
    input wire core_clk_in,
    input wire rstn_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    output reg [7:0] reg_rdata_out,
    output reg reg_rvalid_out,
    input wire clip_event_in,
    input wire current_limit_event_in,
    output reg warn_out,
    output reg fault_out,
    output reg bit_clock_phase_invert_out,
    output reg [2:0] highpass_corner_select_out,
    output reg [5:0] switch_ratio_out,
    output reg line_driver_mode_out
);

// =============================
// Registers
reg clip_flag;
reg current_limit_warning_flag;
reg [7:0] ctrl4;
reg [7:0] line_mode_reg;
reg [7:0] misc3;
reg [7:0] clip_ctrl;
reg [7:0] swfreq;
reg [7:0] next_rdata;
reg [5:0] next_ratio;
reg next_warn;
reg next_fault;
wire clip_en;
wire clip_to_fault;
wire current_limit_warn_mask;
wire wr_ctrl4;
wire wr_line_mode;
wire wr_misc3;
wire wr_clip_ctrl;
wire wr_swfreq;

// =============================
// Address decode
assign clip_en = clip_ctrl[`ASM_BIT_CLIP_EN];
assign clip_to_fault = clip_ctrl[`ASM_BIT_CLIP_ROUTE];
assign current_limit_warn_mask = misc3[`ASM_BIT_ILIM_MASK];
assign wr_ctrl4 = reg_wr_in && (reg_addr_in == `ASM_OFS_CTRL4);
assign wr_line_mode = reg_wr_in && (reg_addr_in == `ASM_OFS_LINE_MODE);
assign wr_misc3 = reg_wr_in && (reg_addr_in == `ASM_OFS_MISC3);
assign wr_clip_ctrl = reg_wr_in && (reg_addr_in == `ASM_OFS_CLIP_CTRL);
assign wr_swfreq = reg_wr_in && (reg_addr_in == `ASM_OFS_SWFREQ);

// =============================
// Status flags
// Plain level sampling; no read clears them
always @(posedge core_clk_in)
begin
    if (!rstn_in)
    begin
        clip_flag <= 1'h0;
        current_limit_warning_flag <= 1'h0;
    end
    else
    begin
        clip_flag <= clip_event_in & clip_en;
        current_limit_warning_flag <= current_limit_event_in;
    end
end

// =============================
// Writable registers
// One process per register; status and unmapped offsets have no enable
always @(posedge core_clk_in)
begin
    if (!rstn_in)
    begin
        ctrl4 <= `ASM_RST_CTRL4;
    end
    else if (wr_ctrl4)
    begin
        ctrl4 <= reg_wdata_in;
    end
end

always @(posedge core_clk_in)
begin
    if (!rstn_in)
    begin
        line_mode_reg <= `ASM_RST_ZERO;
    end
    else if (wr_line_mode)
    begin
        line_mode_reg <= reg_wdata_in;
    end
end

always @(posedge core_clk_in)
begin
    if (!rstn_in)
    begin
        misc3 <= `ASM_RST_ZERO;
    end
    else if (wr_misc3)
    begin
        misc3 <= reg_wdata_in;
    end
end

always @(posedge core_clk_in)
begin
    if (!rstn_in)
    begin
        clip_ctrl <= `ASM_RST_CLIP_CTRL;
    end
    else if (wr_clip_ctrl)
    begin
        clip_ctrl <= reg_wdata_in;
    end
end

always @(posedge core_clk_in)
begin
    if (!rstn_in)
    begin
        swfreq <= `ASM_RST_ZERO;
    end
    else if (wr_swfreq)
    begin
        swfreq <= reg_wdata_in;
    end
end

// =============================
// Read mux
always @*
begin
    next_rdata = `ASM_RST_ZERO;
    case (reg_addr_in)
        `ASM_OFS_CLIP_STATUS: next_rdata = {7'h00, clip_flag};
        `ASM_OFS_ILIM_STATUS: next_rdata = {7'h00, current_limit_warning_flag};
        `ASM_OFS_CTRL4: next_rdata = ctrl4;
        `ASM_OFS_LINE_MODE: next_rdata = line_mode_reg;
        `ASM_OFS_MISC3: next_rdata = misc3;
        `ASM_OFS_CLIP_CTRL: next_rdata = clip_ctrl;
        `ASM_OFS_SWFREQ: next_rdata = swfreq;
        default: next_rdata = `ASM_RST_ZERO;
    endcase
end

// =============================
// Switching ratio decode
// Unlisted codes fall back to 44x, a safe above-band choice
always @*
begin
    case (swfreq[`ASM_SWF_MSB:`ASM_SWF_LSB])
        `ASM_SWF_38: next_ratio = `ASM_RATIO_38;
        `ASM_SWF_44: next_ratio = `ASM_RATIO_44;
        `ASM_SWF_48: next_ratio = `ASM_RATIO_48;
        `ASM_SWF_8: next_ratio = `ASM_RATIO_8;
        `ASM_SWF_10: next_ratio = `ASM_RATIO_10;
        default: next_ratio = `ASM_RATIO_44;
    endcase
end

// =============================
// Pin routing
// Clip drives one pin only; the mask hides current limit from the pin, not the flag
always @*
begin
    next_fault = clip_flag & clip_to_fault;
    next_warn = (clip_flag & ~clip_to_fault)
        | (current_limit_warning_flag & ~current_limit_warn_mask);
end

// =============================
// Bus answer
always @(posedge core_clk_in)
begin
    if (!rstn_in)
    begin
        reg_rdata_out <= `ASM_RST_ZERO;
        reg_rvalid_out <= 1'h0;
    end
    else
    begin
        reg_rvalid_out <= reg_rd_in;
        if (reg_rd_in)
        begin
            reg_rdata_out <= next_rdata;
        end
    end
end

// =============================
// Pin and control outputs
always @(posedge core_clk_in)
begin
    if (!rstn_in)
    begin
        warn_out <= 1'h0;
        fault_out <= 1'h0;
        bit_clock_phase_invert_out <= 1'h0;
        highpass_corner_select_out <= `ASM_RST_HPF;
        switch_ratio_out <= `ASM_RATIO_38;
        line_driver_mode_out <= 1'h0;
    end
    else
    begin
        warn_out <= next_warn;
        fault_out <= next_fault;
        bit_clock_phase_invert_out <= ctrl4[`ASM_BIT_BIT_CLOCK_PHASE_INVERT];
        highpass_corner_select_out <= ctrl4[`ASM_HPF_MSB:`ASM_HPF_LSB];
        switch_ratio_out <= next_ratio;
        line_driver_mode_out <= line_mode_reg[`ASM_BIT_LINE_MODE];
    end
end

endmodule
`default_nettype wire

// >>> tb/asm_host.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Register bus host
module asm_host(input wire core_clk_in,reg_rvalid_out,input wire [7:0] reg_rdata_out,
    output logic reg_wr_in=0,reg_rd_in=0,output logic [7:0] reg_addr_in=0,reg_wdata_in=0);
task acc(input logic w,input logic [7:0] a,d,output logic [7:0] r);
    @(posedge core_clk_in);
    {reg_wr_in,reg_rd_in,reg_addr_in,reg_wdata_in}<={w,!w,a,d};
    @(posedge core_clk_in);
    // Junk on released lines so a stale value cannot pass
    {reg_wr_in,reg_rd_in,reg_addr_in,reg_wdata_in}<={2'b00,~a,~d};
    @(posedge core_clk_in);
    r=reg_rvalid_out?reg_rdata_out:8'hXX;
endtask
endmodule
`default_nettype wire

// >>> tb/asm_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Bus and pin checks
module asm_regs_sva(input wire core_clk_in,rstn_in,reg_rd_in,reg_rvalid_out,clip_event_in,
    current_limit_event_in,warn_out,fault_out,input wire [7:0] reg_addr_in,reg_rdata_out);
default clocking @(posedge core_clk_in); endclocking
default disable iff (!rstn_in);
chk_read_answer: assert property (reg_rd_in|=>reg_rvalid_out) else $error("no rvalid");
chk_no_stray: assert property (!reg_rd_in|=>!reg_rvalid_out) else $error("stray");
chk_rdata_hold: assert property (!reg_rd_in|=>$stable(reg_rdata_out)) else $error("rdata");
chk_clip_zero: assert property (reg_rd_in&&reg_addr_in==8'h24|=>!reg_rdata_out[7:1])
    else $error("clip bits");
chk_ilim_zero: assert property (reg_rd_in&&reg_addr_in==8'h25|=>!reg_rdata_out[7:1])
    else $error("ilim bits");
chk_ilim_flag: assert property (current_limit_event_in[*2]##0(reg_rd_in&&reg_addr_in==8'h25)
    |=>reg_rdata_out[0]) else $error("ilim flag");
chk_fault_idle: assert property (!clip_event_in[*3]|->!fault_out) else $error("fault");
chk_warn_idle: assert property ((!clip_event_in&&!current_limit_event_in)[*3]|->!warn_out)
    else $error("warn");
cover property (warn_out);
cover property (fault_out);
cover property (reg_rvalid_out&&reg_rdata_out[0]);
endmodule
bind asm_status_misc_regs asm_regs_sva i_sva(.*);
`default_nettype wire

// >>> tb/asm_status_misc_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module asm_status_misc_regs_bench;
logic core_clk_in=0,rstn_in=0,clip_event_in=0,current_limit_event_in=0;
wire reg_wr_in,reg_rd_in,reg_rvalid_out,warn_out,fault_out,bit_clock_phase_invert_out;
wire line_driver_mode_out;
wire [7:0] reg_addr_in,reg_wdata_in,reg_rdata_out;
wire [2:0] highpass_corner_select_out;
wire [5:0] switch_ratio_out;
logic [7:0] r;
int n_errors=0,n_tests=0;
initial forever #4 core_clk_in=~core_clk_in;
asm_status_misc_regs i_dut(.*);
asm_host i_host(.*);
task summarize;
    $display("errors %0d checks %0d",n_errors,n_tests);
    if (n_errors==0&&n_tests>0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask
task cmp(input logic [7:0] g,e);
    n_tests++;
    n_errors+=(g!==e);
    if (g!==e)
        $display("ERROR %0t got %h exp %h",$time,g,e);
endtask
task rdc(input logic [7:0] a,e);
    i_host.acc(0,a,8'h00,r);
    cmp(r,e);
endtask
task wrw(input logic [7:0] a,d);
    i_host.acc(1,a,d,r);
    @(posedge core_clk_in);
endtask
task t_ctrl;
    cmp(8'({bit_clock_phase_invert_out,highpass_corner_select_out}),8'h00);
    cmp(8'(switch_ratio_out),8'h26);
    rdc(8'h26,8'h40);
    for (int i=0;i<16;i++)
    begin
        wrw(8'h26,8'hA0|8'(i));
        cmp(8'({bit_clock_phase_invert_out,highpass_corner_select_out}),8'(i));
        rdc(8'h26,8'hA0|8'(i));
    end
endtask
task t_flags;
    clip_event_in<=1;
    wrw(8'h24,8'hFE);
    rdc(8'h24,8'h01);
    rdc(8'h24,8'h01);
    cmp(8'({warn_out,fault_out}),8'h02);
    wrw(8'h22,8'h05);
    cmp(8'({warn_out,fault_out}),8'h01);
    {clip_event_in,current_limit_event_in}<=2'b01;
    wrw(8'h22,8'h01);
    rdc(8'h24,8'h00);
    rdc(8'h25,8'h01);
    cmp(8'(warn_out),8'h01);
    wrw(8'h21,8'h20);
    cmp(8'(warn_out),8'h00);
    rdc(8'h25,8'h01);
endtask
task t_swf;
    logic [5:0] x[6]='{6'h26,6'h2C,6'h30,6'h08,6'h0A,6'h2C};
    for (int i=0;i<6;i++)
    begin
        wrw(8'h27,8'(i));
        cmp(8'(switch_ratio_out),8'(x[i]));
    end
    wrw(8'h00,8'h01);
    cmp(8'(line_driver_mode_out),8'h01);
endtask
initial
begin
    repeat (6) @(posedge core_clk_in);
    rstn_in<=1;
    t_ctrl;
    t_flags;
    t_swf;
    summarize;
end
// Run needs about 180 cycles
initial
begin
    repeat (1000) @(posedge core_clk_in);
    n_errors++;
    summarize;
end
endmodule
`default_nettype wire
